/* File: rtl/tss_sequencer.sv */
// power-up sequencer and fault supervisor for a three-output display supply
// assumes comparator flags and the power-off pin arrive asynchronously to mclk
`timescale 1ns/1ps

module tss_sequencer #(
  parameter bit DELAYED = 1'b0,
  parameter logic [tss_pkg::TMR_W-1:0] MAIN_TO_NEG_CYC = tss_pkg::MAIN_TO_NEG_CYC,
  parameter logic [tss_pkg::TMR_W-1:0] NEG_TO_POS_CYC = tss_pkg::NEG_TO_POS_CYC,
  parameter logic [tss_pkg::TMR_W-1:0] SOFT_PHASE_CYC = tss_pkg::SOFT_PHASE_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic power_off_request_n,
  input wire tss_pkg::tss_sense_t sensePins,
  output tss_pkg::tss_drive_t drive,
  input wire logic readyIn,
  output logic readyOut,
  output logic readyOe_n
);

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  tss_pkg::tss_sense_t senseMeta_q, sense_q;
  logic pwrMeta_q, pwrOn_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      senseMeta_q <= tss_pkg::SENSE_RESET;
      sense_q <= tss_pkg::SENSE_RESET;
      pwrMeta_q <= 1'b0;
      pwrOn_q <= 1'b0;
    end else begin
      senseMeta_q <= sensePins;
      sense_q <= senseMeta_q;
      pwrMeta_q <= power_off_request_n;
      pwrOn_q <= pwrMeta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stage decode

  function automatic logic atOrPast(tss_pkg::tss_state_t s, tss_pkg::tss_state_t stage);
    atOrPast = (s >= stage);
  endfunction

  tss_pkg::tss_state_t state_q, state_d;
  logic refSeen_q;
  logic [tss_pkg::TMR_W-1:0] mainTmr_q, negTmr_q, phaseTmr_q;
  logic [1:0] phase_q;

  // reference fault only counts after it was once good; the no-delay variant
  // leaves the reference stage before it has settled
  wire refFaultHit = refSeen_q && sense_q.refFault && atOrPast(state_q, tss_pkg::ST_MAIN);
  wire mainFaultHit = sense_q.mainBoostSenseFault && atOrPast(state_q, tss_pkg::ST_NEG);
  wire negFaultHit = sense_q.negPumpSenseFault && atOrPast(state_q, tss_pkg::ST_POS);
  wire posFaultHit = sense_q.posPumpSenseFault && (state_q == tss_pkg::ST_READY);
  wire mainDelayDone = !DELAYED || (mainTmr_q >= MAIN_TO_NEG_CYC);
  wire negDelayDone = !DELAYED || (negTmr_q >= NEG_TO_POS_CYC);
  wire mainOn = atOrPast(state_q, tss_pkg::ST_MAIN);
  wire negOn = atOrPast(state_q, tss_pkg::ST_NEG);

  //////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_d = state_q;
    if (!pwrOn_q) begin
      state_d = tss_pkg::ST_OFF;
    end else if (refFaultHit) begin
      state_d = tss_pkg::ST_REF;
    end else if (mainFaultHit) begin
      state_d = tss_pkg::ST_MAIN;
    end else if (negFaultHit) begin
      state_d = tss_pkg::ST_NEG;
    end else if (posFaultHit) begin
      state_d = tss_pkg::ST_POS;
    end else begin
      case (state_q)
        tss_pkg::ST_OFF: state_d = tss_pkg::ST_REF;
        tss_pkg::ST_REF: begin
          // once seen good, a faulted reference must come back up before main restarts
          if (sense_q.refUp || (!DELAYED && !refSeen_q)) begin
            state_d = tss_pkg::ST_MAIN;
          end
        end
        tss_pkg::ST_MAIN: begin
          if (sense_q.mainBoostSenseUp && mainDelayDone) begin
            state_d = tss_pkg::ST_NEG;
          end
        end
        tss_pkg::ST_NEG: begin
          if (sense_q.negPumpSenseUp && negDelayDone) begin
            state_d = tss_pkg::ST_POS;
          end
        end
        tss_pkg::ST_POS: begin
          if (sense_q.posPumpSenseUp) begin
            state_d = tss_pkg::ST_READY;
          end
        end
        tss_pkg::ST_READY: state_d = tss_pkg::ST_READY;
        default: state_d = tss_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= tss_pkg::ST_OFF;
      refSeen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      refSeen_q <= pwrOn_q && (refSeen_q || sense_q.refUp);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // delay timers, cleared whenever their stage is off

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mainTmr_q <= '0;
      negTmr_q <= '0;
    end else begin
      mainTmr_q <= !mainOn ? '0 : (mainDelayDone ? mainTmr_q : mainTmr_q + 1'b1);
      negTmr_q <= !negOn ? '0 : (negDelayDone ? negTmr_q : negTmr_q + 1'b1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // soft-start phases of the main boost current limit

  wire phaseEnd = (phaseTmr_q == SOFT_PHASE_CYC - 1'b1);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= tss_pkg::LIMIT_FIRST;
      phaseTmr_q <= '0;
    end else if (!mainOn) begin
      phase_q <= tss_pkg::LIMIT_FIRST;
      phaseTmr_q <= '0;
    end else if (sense_q.mainBoostSenseUp) begin
      phase_q <= tss_pkg::LIMIT_FULL;
      phaseTmr_q <= '0;
    end else if (phase_q != tss_pkg::LIMIT_FULL) begin
      phase_q <= phaseEnd ? phase_q + 2'h1 : phase_q;
      phaseTmr_q <= phaseEnd ? '0 : phaseTmr_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, registered from the next state; limitStep is registered from the current soft-start phase

  tss_pkg::tss_drive_t drive_d, drive_q;
  logic readyOe_n_q;

  always_comb begin
    drive_d.refEnable = atOrPast(state_d, tss_pkg::ST_REF);
    drive_d.refPullDown = !drive_d.refEnable;
    drive_d.mainBoostEnable = atOrPast(state_d, tss_pkg::ST_MAIN);
    drive_d.limitStep = phase_q;
    drive_d.negPumpEnable = atOrPast(state_d, tss_pkg::ST_NEG);
    drive_d.posPumpEnable = atOrPast(state_d, tss_pkg::ST_POS);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      drive_q <= tss_pkg::DRIVE_OFF;
      readyOe_n_q <= 1'b1;
    end else begin
      drive_q <= drive_d;
      readyOe_n_q <= (state_d != tss_pkg::ST_READY);
    end
  end

  // open drain: only ever pulls low; the pin level is not needed inside
  assign drive = drive_q;
  assign readyOut = 1'b0;
  assign readyOe_n = readyOe_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  shutdown_all_off_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !pwrOn_q |=> !drive_q.refEnable && drive_q.refPullDown && !drive_q.mainBoostEnable
      && !drive_q.negPumpEnable && !drive_q.posPumpEnable && readyOe_n_q)
    else $error("stage still on during shutdown");

  stage_order_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (drive_q.posPumpEnable |-> drive_q.negPumpEnable)
      and (drive_q.negPumpEnable |-> drive_q.mainBoostEnable)
      and (drive_q.mainBoostEnable |-> drive_q.refEnable && !drive_q.refPullDown))
    else $error("stage on while an earlier one is off");

  restart_ref_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $rose(pwrOn_q) |=> drive_q.refEnable ##1 drive_q.refEnable)
    else $error("sequence did not start at the reference");

  neg_delay_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $rose(drive_q.negPumpEnable) |-> !DELAYED
      || ($past(mainTmr_q) >= MAIN_TO_NEG_CYC && $past(sense_q.mainBoostSenseUp)))
    else $error("negative pump enabled too early");

  pos_delay_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $rose(drive_q.posPumpEnable) |-> $past(sense_q.negPumpSenseUp)
      && (!DELAYED || $past(negTmr_q) >= NEG_TO_POS_CYC))
    else $error("positive pump enabled too early");

  ready_release_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (!readyOe_n_q && sense_q.posPumpSenseFault) |=> readyOe_n_q)
    else $error("ready held through a fault");

  ready_cause_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $fell(readyOe_n_q) |-> $past(sense_q.posPumpSenseUp) && drive_q.posPumpEnable)
    else $error("ready without positive output up");

  neg_fault_keep_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (negFaultHit && !mainFaultHit && !refFaultHit && pwrOn_q)
      |=> !drive_q.posPumpEnable && drive_q.negPumpEnable && drive_q.mainBoostEnable)
    else $error("wrong stages dropped on negative fault");

  soft_step_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (mainOn && pwrOn_q && !sense_q.mainBoostSenseUp && phaseEnd
      && phase_q != tss_pkg::LIMIT_FULL && state_d >= tss_pkg::ST_MAIN)
      |=> phase_q == $past(phase_q) + 2'h1)
    else $error("soft-start phase did not advance");

endmodule // tss_sequencer

/* File: rtl/tss_pkg.sv */
// shared types and constants of the display supply sequencer
// assumes a single 100 MHz clock and comparator flags from the analog side
package tss_pkg;

  // clock rate and documented times
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MAIN_TO_NEG_MS = 16;
  localparam int unsigned NEG_TO_POS_MS = 4;
  localparam int unsigned SOFT_PHASE_MS = 1;

  localparam int unsigned TMR_W = 21;
  // least times, whole cycles (exact at this rate)
  localparam logic [TMR_W-1:0] MAIN_TO_NEG_CYC = TMR_W'(MAIN_TO_NEG_MS * (CLK_HZ / 1000));
  localparam logic [TMR_W-1:0] NEG_TO_POS_CYC = TMR_W'(NEG_TO_POS_MS * (CLK_HZ / 1000));
  localparam logic [TMR_W-1:0] SOFT_PHASE_CYC = TMR_W'(SOFT_PHASE_MS * (CLK_HZ / 1000));

  // soft-start current limit steps, quarter to full
  localparam logic [1:0] LIMIT_FIRST = 2'h0;
  localparam logic [1:0] LIMIT_FULL = 2'h3;

  // sequencer stages in power-up order
  typedef enum {
    ST_OFF,
    ST_REF,
    ST_MAIN,
    ST_NEG,
    ST_POS,
    ST_READY
  } tss_state_t;

  // comparator flags: up = above power-up level, fault = below fault level
  typedef struct packed {
    logic refUp;
    logic refFault;
    logic mainBoostSenseUp;
    logic mainBoostSenseFault;
    logic negPumpSenseUp;
    logic negPumpSenseFault;
    logic posPumpSenseUp;
    logic posPumpSenseFault;
  } tss_sense_t;

  localparam tss_sense_t SENSE_RESET = '0;

  // converter controls
  typedef struct packed {
    logic refEnable;
    logic refPullDown;
    logic mainBoostEnable;
    logic [1:0] limitStep;
    logic negPumpEnable;
    logic posPumpEnable;
  } tss_drive_t;

  localparam tss_drive_t DRIVE_OFF = '{refEnable: 1'b0, refPullDown: 1'b1,
    mainBoostEnable: 1'b0, limitStep: LIMIT_FIRST, negPumpEnable: 1'b0, posPumpEnable: 1'b0};

endpackage

/* File: sim/tss_host_model.sv */
// host side of the supply sequencer: power-off request and pulled-up ready pin
// assumes the bench sets the request level and watches readyPin
`timescale 1ns/1ps
module tss_host_model (
  input wire logic powerOn,
  input wire logic readyOut,
  input wire logic readyOe_n,
  output logic power_off_request_n,
  output logic readyPin
);
  assign power_off_request_n = powerOn;
  // pull-up wins whenever the open drain lets go
  assign readyPin = readyOe_n ? 1'b1 : readyOut;
endmodule // tss_host_model

/* File: sim/tss_sequencer_tb.sv */
// bench for the supply sequencer: both variants share pins, short timers
// assumes the host model resolves the ready pin of the no-delay instance
`timescale 1ns/1ps
module tss_sequencer_tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic powerOn = 1'b0;
  tss_pkg::tss_sense_t sense = tss_pkg::SENSE_RESET;
  tss_pkg::tss_sense_t s = tss_pkg::SENSE_RESET;
  tss_pkg::tss_drive_t drv;
  tss_pkg::tss_drive_t dlyDrv;
  logic pwrN, rdyOut, rdyOe_n, rdyPin, dlyOut, dlyOe_n;
  int fail_count = 0;
  int checked = 0;

  always #5 mclk = ~mclk;

  tss_host_model host (.powerOn(powerOn), .readyOut(rdyOut), .readyOe_n(rdyOe_n),
    .power_off_request_n(pwrN), .readyPin(rdyPin));
  // no-delay instance ignores its timers, so only the soft-start phase is shortened
  tss_sequencer #(.SOFT_PHASE_CYC(21'ha)) dut (.mclk(mclk), .reset_n(reset_n),
    .power_off_request_n(pwrN), .sensePins(sense), .drive(drv), .readyIn(rdyPin),
    .readyOut(rdyOut), .readyOe_n(rdyOe_n));
  // delayed timers short but visible; its soft-start keeps the long default
  tss_sequencer #(.DELAYED(1'b1), .MAIN_TO_NEG_CYC(21'h50), .NEG_TO_POS_CYC(21'h28))
    dutDly (.mclk(mclk), .reset_n(reset_n),
    .power_off_request_n(pwrN), .sensePins(sense), .drive(dlyDrv), .readyIn(dlyOe_n),
    .readyOut(dlyOut), .readyOe_n(dlyOe_n));

  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic put();
    @(posedge mclk);
    sense <= s;
    #1;
  endtask

  task automatic bound(input int i, input int lim);
    if (i >= lim) begin
      fail_count++;
      results();
    end
  endtask

  task automatic cmpBit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cmpDrive(input string what, input tss_pkg::tss_drive_t exp,
      input tss_pkg::tss_drive_t got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic offState();
    cmpDrive("drive", tss_pkg::DRIVE_OFF, drv);
    cmpDrive("dlyDrive", tss_pkg::DRIVE_OFF, dlyDrv);
    cmpBit("readyPin", 1'b1, rdyPin);
  endtask

  // reference comes up alone before the main converter
  task automatic startRef();
    @(posedge mclk);
    powerOn <= 1'b1;
    for (int i = 0; drv.refEnable !== 1'b1; i++) begin
      bound(i, 10);
      step(1);
    end
    cmpBit("mainEnable", 1'b0, drv.mainBoostEnable);
    cmpBit("refPullDown", 1'b0, drv.refPullDown);
  endtask

  task automatic softStart();
    for (int i = 0; drv.mainBoostEnable !== 1'b1; i++) begin
      bound(i, 5);
      step(1);
    end
    cmpBit("limitLow", 1'b1, drv.limitStep === tss_pkg::LIMIT_FIRST);
    step(3);
    cmpBit("dlyMainEnable", 1'b0, dlyDrv.mainBoostEnable);
    s.refUp = 1'b1;
    put();
    for (int i = 0; dlyDrv.mainBoostEnable !== 1'b1; i++) begin
      bound(i, 8);
      step(1);
    end
    step(34);
    cmpBit("limitFull", 1'b1, drv.limitStep === tss_pkg::LIMIT_FULL);
    cmpBit("negEnable", 1'b0, drv.negPumpEnable);
  endtask

  task automatic delayedGaps();
    s.mainBoostSenseUp = 1'b1;
    put();
    step(5);
    cmpBit("negEnable", 1'b1, drv.negPumpEnable);
    cmpBit("dlyNegEarly", 1'b0, dlyDrv.negPumpEnable);
    step(30);
    cmpBit("dlyNegEarly", 1'b0, dlyDrv.negPumpEnable);
    for (int i = 0; dlyDrv.negPumpEnable !== 1'b1; i++) begin
      bound(i, 25);
      step(1);
    end
    s.negPumpSenseUp = 1'b1;
    put();
    step(5);
    cmpBit("posEnable", 1'b1, drv.posPumpEnable);
    cmpBit("dlyPosEarly", 1'b0, dlyDrv.posPumpEnable);
    step(25);
    cmpBit("dlyPosEarly", 1'b0, dlyDrv.posPumpEnable);
    for (int i = 0; dlyDrv.posPumpEnable !== 1'b1; i++) begin
      bound(i, 25);
      step(1);
    end
  endtask

  task automatic readyAndFaults();
    s.posPumpSenseUp = 1'b1;
    put();
    step(5);
    cmpBit("readyPin", 1'b0, rdyPin);
    cmpBit("dlyReadyOe_n", 1'b0, dlyOe_n);
    cmpBit("dlyReadyOut", 1'b0, dlyOut);
    s.posPumpSenseUp = 1'b0;
    s.posPumpSenseFault = 1'b1;
    put();
    step(5);
    cmpBit("readyPin", 1'b1, rdyPin);
    cmpBit("posEnable", 1'b1, drv.posPumpEnable);
    s = '{refUp: 1'b1, mainBoostSenseUp: 1'b1, negPumpSenseFault: 1'b1, default: 1'b0};
    put();
    step(5);
    cmpBit("posEnable", 1'b0, drv.posPumpEnable);
    cmpBit("negEnable", 1'b1, drv.negPumpEnable);
    cmpBit("mainEnable", 1'b1, drv.mainBoostEnable);
    cmpBit("readyPin", 1'b1, rdyPin);
    s.negPumpSenseFault = 1'b0;
    put();
    step(5);
    cmpBit("posEnable", 1'b0, drv.posPumpEnable);
    s.negPumpSenseUp = 1'b1;
    put();
    step(5);
    cmpBit("posEnable", 1'b1, drv.posPumpEnable);
  endtask

  // main then reference faults from the ready state, then full recovery
  task automatic upstreamFaults();
    s.posPumpSenseUp = 1'b1;
    put();
    step(5);
    cmpBit("readyPin", 1'b0, rdyPin);
    s.mainBoostSenseUp = 1'b0;
    s.mainBoostSenseFault = 1'b1;
    put();
    step(5);
    cmpBit("negEnable", 1'b0, drv.negPumpEnable);
    cmpBit("mainEnable", 1'b1, drv.mainBoostEnable);
    cmpBit("readyPin", 1'b1, rdyPin);
    s.refUp = 1'b0;
    s.refFault = 1'b1;
    put();
    step(5);
    cmpBit("mainEnable", 1'b0, drv.mainBoostEnable);
    cmpBit("dlyMainEnable", 1'b0, dlyDrv.mainBoostEnable);
    cmpBit("refEnable", 1'b1, drv.refEnable);
    s = '{refUp: 1'b1, mainBoostSenseUp: 1'b1, negPumpSenseUp: 1'b1,
      posPumpSenseUp: 1'b1, default: 1'b0};
    put();
    step(8);
    cmpBit("readyPin", 1'b0, rdyPin);
  endtask

  task automatic shutdown();
    @(posedge mclk);
    powerOn <= 1'b0;
    step(5);
    offState();
    startRef();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    step(1);
    offState();
    @(posedge mclk);
    reset_n <= 1'b1;
    step(3);
    offState();
    startRef();
    softStart();
    delayedGaps();
    readyAndFaults();
    upstreamFaults();
    shutdown();
    results();
  end
endmodule // tss_sequencer_tb
